//--- src/svs_pkg.sv
// package: constants and types for the streaming vector system registers
package svs_pkg;
    // exception levels
    typedef enum logic [1:0] {
        SVS_EL0 = 2'h0,
        SVS_EL1 = 2'h1,
        SVS_EL2 = 2'h2,
        SVS_EL3 = 2'h3
    } svs_el_t;

    // register selectors on the move port
    typedef enum logic [2:0] {
        SVS_SEL_CTRL_LOW = 3'h0,
        SVS_SEL_CTRL_HYP = 3'h1,
        SVS_SEL_CTRL_TOP = 3'h2,
        SVS_SEL_IDENT    = 3'h3,
        SVS_SEL_PRIO     = 3'h4
    } svs_sel_t;

    // access outcome
    typedef enum logic [2:0] {
        SVS_RES_DONE   = 3'h0,
        SVS_RES_UNDEF  = 3'h1,
        SVS_RES_TRAP   = 3'h2,
        SVS_RES_VIRTUALIZATION_MEMORY_PAGE  = 3'h3
    } svs_res_t;

    // move handshake state, one-hot
    typedef enum logic [1:0] {
        SVS_ST_IDLE = 2'b01,
        SVS_ST_RESP = 2'b10
    } svs_state_t;

    localparam logic [5:0]  SVS_EC_TRAP_CTRL  = 6'h1D;
    localparam logic [5:0]  SVS_EC_TRAP_SYS   = 6'h18;
    localparam logic [11:0] SVS_VIRTUALIZATION_MEMORY_PAGE_CTRL    = 12'h01F0;
    localparam int          SVS_FULL_SET_BIT  = 31;
    localparam int          SVS_LEN_LSB       = 0;
    localparam int          SVS_LEN_W         = 4;
    localparam int          SVS_PRIO_W        = 4;
    localparam int          SVS_IMPL_LSB      = 24;
    localparam int          SVS_REV_LSB       = 16;
    localparam int          SVS_PSUP_BIT      = 15;
    localparam int          SVS_AFF_LSB       = 0;
    localparam int          SVS_AFF_W         = 12;
    localparam int          SVS_LEN_UNIT_BITS = 128;
    localparam int          SVS_LEN_MAX_BITS  = 2048;
    localparam logic [63:0] SVS_ZERO64        = 64'h0000_0000_0000_0000;
    // supported lengths mask: bit k set means 128<<k supported (k = 0..4)
    localparam logic [4:0]  SVS_LEN_SUPPORT   = 5'h1F;
endpackage

//--- src/svs_len_if.sv
// interface: length request and effective length between top and resolver
interface svs_len_if;
    logic [3:0] length_request;
    logic [4:0] streaming_vector_length;
    modport req (output length_request, input streaming_vector_length);
    modport res (input length_request, output streaming_vector_length);
endinterface

//--- src/svs_len_resolve.sv
// length resolver: request to effective supported streaming vector length
module svs_len_resolve
    import svs_pkg::*;
#(
    parameter logic [4:0] SUPPORT = SVS_LEN_SUPPORT
) (
    svs_len_if.res lif
);
    // result is a one-hot power of two index: bit k means 128<<k bits
    function automatic logic [4:0] pick(input logic [3:0] req, input logic [4:0] sup);
        logic [4:0] r;
        logic       found;
        r = 5'h00;
        found = 1'b0;
        // round down to a supported power of two
        for (int k = 4; k >= 0; k--) begin
            if (!found && sup[k] && ((5'd1 << k) <= ({1'b0, req} + 5'd1))) begin
                r = 5'(5'd1 << k);
                found = 1'b1;
            end
        end
        // below minimum uses the minimum
        for (int k = 4; k >= 0; k--) begin
            if (!found && sup[k]) begin
                r = 5'(5'd1 << k);
            end
        end
        return r;
    endfunction

    assign lif.streaming_vector_length = pick(lif.length_request, SUPPORT);
endmodule

//--- src/svs_sysregs.sv
// top: streaming vector system registers with move-instruction access checks
module svs_sysregs
    import svs_pkg::*;
#(
    parameter bit          STREAMING_FEATURE = 1'b1,
    parameter bit          HAVE_LEVEL3       = 1'b1,
    parameter bit          HAVE_LEVEL2       = 1'b1,
    parameter bit          FULL_SET_FEATURE  = 1'b1,
    parameter bit          ID_TRAP_FEATURE   = 1'b1,
    parameter logic [7:0]  IMPLEMENTER       = 8'h5A,  // arbitrary value
    parameter logic [7:0]  REVISION          = 8'h01,  // arbitrary value
    parameter bit          PRIORITY_SUPPORT  = 1'b1,
    parameter logic [11:0] UNIT_AFFINITY     = 12'h000,
    parameter logic [4:0]  LEN_SUPPORT       = SVS_LEN_SUPPORT
) (
    // clock and reset
    input  wire logic        CORE_CLK_I,
    input  wire logic        RST_N_I,
    // move instruction port
    input  wire logic        MOVE_VALID_I,
    input  wire logic        MOVE_WRITE_I,
    input  wire logic [2:0]  MOVE_SEL_I,
    input  wire logic [63:0] MOVE_WDATA_I,
    output logic             MOVE_READY_O,
    output logic             RESP_VALID_O,
    output logic [2:0]       RESP_KIND_O,
    output logic [1:0]       RESP_TRAP_EL_O,
    output logic [5:0]       RESP_TRAP_CLASS_O,
    output logic [63:0]      RESP_RDATA_O,
    output logic [11:0]      RESP_VIRTUALIZATION_MEMORY_PAGE_OFFSET_O,
    output logic [63:0]      RESP_VIRTUALIZATION_MEMORY_PAGE_DATA_O,
    // processor state and controls from other registers
    input  wire logic [1:0]  CUR_EL_I,
    input  wire logic        STREAMING_MODE_I,
    input  wire logic        HALTED_I,
    input  wire logic        SECURE_DEBUG_DISABLE_I,
    input  wire logic        LEVEL2_ENABLED_I,
    input  wire logic        HOST_REDIRECT_I,
    input  wire logic        NESTED_VIRT_ENABLE_I,
    input  wire logic        NESTED_VIRT_LEVEL1_I,
    input  wire logic        NESTED_VIRT_MEM_REDIRECT_I,
    input  wire logic [1:0]  LEVEL1_STREAM_ACCESS_ENABLE_I,
    input  wire logic        LEVEL2_STREAM_TRAP_I,
    input  wire logic [1:0]  LEVEL2_STREAM_ACCESS_ENABLE_I,
    input  wire logic        LEVEL3_STREAM_ENABLE_I,
    input  wire logic        GENERAL_TRAP_ROUTING_I,
    input  wire logic        GROUP1_ID_TRAP_I,
    input  wire logic        PRIORITY_MAPPING_ENABLE_I,
    input  wire logic [63:0] PRIORITY_MAP_I,
    // streaming execution controls
    output logic             FULL_SET_LEGAL_O,
    output logic [4:0]       STREAMING_VECTOR_LENGTH_O,
    output logic [3:0]       EFFECTIVE_PRIORITY_O,
    output logic [63:0]      STREAMING_CONTROL_LOW_O,
    output logic [63:0]      STREAMING_CONTROL_HYP_O
);
    localparam bit TOP_EXISTS = STREAMING_FEATURE && HAVE_LEVEL3;

    svs_len_if lif ();

    svs_state_t state;
    logic [63:0] ctrl_low;
    logic [63:0] ctrl_hyp;
    logic        full_set;
    logic [3:0]  len_field;
    logic [3:0]  prio_field;
    logic [63:0] ident;

    // combinational decision for the current request
    svs_res_t    next_kind;
    logic [1:0]  next_trap_el;
    logic [5:0]  next_class;
    logic [63:0] next_rdata;

    svs_len_resolve #(
        .SUPPORT (LEN_SUPPORT)
    ) u_len (
        .lif (lif.res)
    );

    // resolver reads the stored field with no extra delay
    assign lif.length_request = len_field;

    always_comb begin
        ident = SVS_ZERO64;
        ident[SVS_IMPL_LSB +: 8] = IMPLEMENTER;
        ident[SVS_REV_LSB +: 8] = REVISION;
        ident[SVS_PSUP_BIT] = PRIORITY_SUPPORT;
        ident[SVS_AFF_LSB +: SVS_AFF_W] = UNIT_AFFINITY;
    end

    function automatic logic [63:0] top_view(input logic fs, input logic [3:0] len);
        logic [63:0] v;
        v = SVS_ZERO64;
        // full set bit reads zero without the feature
        v[SVS_FULL_SET_BIT] = fs & FULL_SET_FEATURE;
        v[SVS_LEN_LSB +: SVS_LEN_W] = len;
        return v;
    endfunction

    // level-3 enable check shared by the lower control registers and the priority register
    function automatic logic level3_blocks();
        return HAVE_LEVEL3 && !LEVEL3_STREAM_ENABLE_I;
    endfunction

    always_comb begin
        next_kind = SVS_RES_UNDEF;
        next_trap_el = SVS_EL0;
        next_class = 6'h00;
        next_rdata = SVS_ZERO64;
        case (MOVE_SEL_I)
            SVS_SEL_CTRL_LOW, SVS_SEL_CTRL_HYP: begin
                if (!STREAMING_FEATURE) begin
                    next_kind = SVS_RES_UNDEF;
                end else if (CUR_EL_I == SVS_EL3) begin
                    if (!LEVEL3_STREAM_ENABLE_I) begin
                        next_kind = SVS_RES_TRAP;
                        next_trap_el = SVS_EL3;
                        next_class = SVS_EC_TRAP_CTRL;
                    end else begin
                        next_kind = SVS_RES_DONE;
                    end
                end else if (CUR_EL_I == SVS_EL2) begin
                    if (HALTED_I && SECURE_DEBUG_DISABLE_I && level3_blocks()) begin
                        next_kind = SVS_RES_UNDEF;
                    end else if ((!HOST_REDIRECT_I && LEVEL2_STREAM_TRAP_I) ||
                                 (HOST_REDIRECT_I && !LEVEL2_STREAM_ACCESS_ENABLE_I[0])) begin
                        next_kind = SVS_RES_TRAP;
                        next_trap_el = SVS_EL2;
                        next_class = SVS_EC_TRAP_CTRL;
                    end else if (level3_blocks()) begin
                        next_kind = SVS_RES_TRAP;
                        next_trap_el = SVS_EL3;
                        next_class = SVS_EC_TRAP_CTRL;
                    end else begin
                        next_kind = SVS_RES_DONE;
                    end
                end else if (CUR_EL_I == SVS_EL1 && MOVE_SEL_I == SVS_SEL_CTRL_LOW) begin
                    if (HALTED_I && SECURE_DEBUG_DISABLE_I && level3_blocks()) begin
                        next_kind = SVS_RES_UNDEF;
                    end else if (!LEVEL1_STREAM_ACCESS_ENABLE_I[0]) begin
                        next_kind = SVS_RES_TRAP;
                        next_trap_el = SVS_EL1;
                        next_class = SVS_EC_TRAP_CTRL;
                    end else if (LEVEL2_ENABLED_I &&
                                 ((!HOST_REDIRECT_I && LEVEL2_STREAM_TRAP_I) ||
                                  (HOST_REDIRECT_I && !LEVEL2_STREAM_ACCESS_ENABLE_I[0]))) begin
                        next_kind = SVS_RES_TRAP;
                        next_trap_el = SVS_EL2;
                        next_class = SVS_EC_TRAP_CTRL;
                    end else if (level3_blocks()) begin
                        next_kind = SVS_RES_TRAP;
                        next_trap_el = SVS_EL3;
                        next_class = SVS_EC_TRAP_CTRL;
                    end else if (LEVEL2_ENABLED_I && NESTED_VIRT_MEM_REDIRECT_I &&
                                 NESTED_VIRT_LEVEL1_I && NESTED_VIRT_ENABLE_I) begin
                        next_kind = SVS_RES_VIRTUALIZATION_MEMORY_PAGE;
                    end else begin
                        next_kind = SVS_RES_DONE;
                    end
                end else if (CUR_EL_I == SVS_EL1 && LEVEL2_ENABLED_I && NESTED_VIRT_ENABLE_I) begin
                    next_kind = SVS_RES_TRAP;
                    next_trap_el = SVS_EL2;
                    next_class = SVS_EC_TRAP_SYS;
                end
                // host redirect selects hyp copy at level 2
                if (MOVE_SEL_I == SVS_SEL_CTRL_HYP ||
                    (CUR_EL_I == SVS_EL2 && HOST_REDIRECT_I)) begin
                    next_rdata = ctrl_hyp;
                end else begin
                    next_rdata = ctrl_low;
                end
            end
            SVS_SEL_CTRL_TOP: begin
                if (!TOP_EXISTS || CUR_EL_I != SVS_EL3) begin
                    next_kind = SVS_RES_UNDEF;
                end else if (!LEVEL3_STREAM_ENABLE_I) begin
                    next_kind = SVS_RES_TRAP;
                    next_trap_el = SVS_EL3;
                    next_class = SVS_EC_TRAP_CTRL;
                end else begin
                    next_kind = SVS_RES_DONE;
                end
                // direct read returns the field as written
                next_rdata = top_view(full_set, len_field);
            end
            SVS_SEL_IDENT: begin
                next_rdata = ident;
                if (!STREAMING_FEATURE || MOVE_WRITE_I) begin
                    next_kind = SVS_RES_UNDEF;
                end else if (CUR_EL_I == SVS_EL0) begin
                    if (ID_TRAP_FEATURE) begin
                        next_kind = SVS_RES_TRAP;
                        next_class = SVS_EC_TRAP_SYS;
                        next_trap_el = (LEVEL2_ENABLED_I && GENERAL_TRAP_ROUTING_I) ?
                                       SVS_EL2 : SVS_EL1;
                    end
                end else if (CUR_EL_I == SVS_EL1 && LEVEL2_ENABLED_I && GROUP1_ID_TRAP_I) begin
                    next_kind = SVS_RES_TRAP;
                    next_trap_el = SVS_EL2;
                    next_class = SVS_EC_TRAP_SYS;
                end else begin
                    next_kind = SVS_RES_DONE;
                end
            end
            SVS_SEL_PRIO: begin
                if (!STREAMING_FEATURE || CUR_EL_I == SVS_EL0) begin
                    next_kind = SVS_RES_UNDEF;
                end else if (level3_blocks()) begin
                    next_kind = SVS_RES_TRAP;
                    next_trap_el = SVS_EL3;
                    next_class = SVS_EC_TRAP_SYS;
                end else begin
                    next_kind = SVS_RES_DONE;
                end
                next_rdata = SVS_ZERO64;
                next_rdata[SVS_PRIO_W-1:0] = PRIORITY_SUPPORT ? prio_field : 4'h0;
            end
            default: begin
                next_kind = SVS_RES_UNDEF;
            end
        endcase
        if (MOVE_WRITE_I || next_kind != SVS_RES_DONE) begin
            next_rdata = SVS_ZERO64;
        end
    end

    wire logic take = MOVE_VALID_I && (state == SVS_ST_IDLE);
    wire logic do_write = take && MOVE_WRITE_I && (next_kind == SVS_RES_DONE);

    // handshake state
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state <= SVS_ST_IDLE;
        end else begin
            case (state)
                SVS_ST_IDLE: state <= take ? SVS_ST_RESP : SVS_ST_IDLE;
                SVS_ST_RESP: state <= SVS_ST_IDLE;
                default:     state <= SVS_ST_IDLE;
            endcase
        end
    end

    // response registers
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RESP_KIND_O <= SVS_RES_DONE;
            RESP_TRAP_EL_O <= SVS_EL0;
            RESP_TRAP_CLASS_O <= 6'h00;
            RESP_RDATA_O <= SVS_ZERO64;
            RESP_VIRTUALIZATION_MEMORY_PAGE_OFFSET_O <= 12'h000;
            RESP_VIRTUALIZATION_MEMORY_PAGE_DATA_O <= SVS_ZERO64;
        end else if (take) begin
            RESP_KIND_O <= next_kind;
            RESP_TRAP_EL_O <= next_trap_el;
            RESP_TRAP_CLASS_O <= next_class;
            RESP_RDATA_O <= next_rdata;
            // memory page store offset and data
            RESP_VIRTUALIZATION_MEMORY_PAGE_OFFSET_O <= (next_kind == SVS_RES_VIRTUALIZATION_MEMORY_PAGE) ? SVS_VIRTUALIZATION_MEMORY_PAGE_CTRL : 12'h000;
            RESP_VIRTUALIZATION_MEMORY_PAGE_DATA_O <= (next_kind == SVS_RES_VIRTUALIZATION_MEMORY_PAGE && MOVE_WRITE_I) ?
                                 MOVE_WDATA_I : SVS_ZERO64;
        end
    end

    // lower control copies, kept whole for the neighbouring logic
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl_low <= SVS_ZERO64;
            ctrl_hyp <= SVS_ZERO64;
        end else if (do_write && (MOVE_SEL_I == SVS_SEL_CTRL_LOW ||
                                  MOVE_SEL_I == SVS_SEL_CTRL_HYP)) begin
            if (MOVE_SEL_I == SVS_SEL_CTRL_HYP || (CUR_EL_I == SVS_EL2 && HOST_REDIRECT_I)) begin
                ctrl_hyp <= MOVE_WDATA_I;
            end else begin
                ctrl_low <= MOVE_WDATA_I;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (do_write && MOVE_SEL_I == SVS_SEL_CTRL_TOP) begin
            full_set <= MOVE_WDATA_I[SVS_FULL_SET_BIT] & FULL_SET_FEATURE;
            len_field <= MOVE_WDATA_I[SVS_LEN_LSB +: SVS_LEN_W];
        end
        if (do_write && MOVE_SEL_I == SVS_SEL_PRIO && PRIORITY_SUPPORT) begin
            prio_field <= MOVE_WDATA_I[SVS_PRIO_W-1:0];
        end
    end

    assign MOVE_READY_O = (state == SVS_ST_IDLE);
    assign RESP_VALID_O = (state == SVS_ST_RESP);
    assign STREAMING_CONTROL_LOW_O = ctrl_low;
    assign STREAMING_CONTROL_HYP_O = ctrl_hyp;

    assign FULL_SET_LEGAL_O = STREAMING_MODE_I & full_set & FULL_SET_FEATURE;
    assign STREAMING_VECTOR_LENGTH_O = STREAMING_MODE_I ? lif.streaming_vector_length : 5'h00;

    // larger value means more resource downstream
    always_comb begin
        if (!PRIORITY_SUPPORT) begin
            EFFECTIVE_PRIORITY_O = 4'h0;
        end else if ((CUR_EL_I == SVS_EL1 || CUR_EL_I == SVS_EL0) && HAVE_LEVEL2 &&
                     LEVEL2_ENABLED_I && PRIORITY_MAPPING_ENABLE_I) begin
            EFFECTIVE_PRIORITY_O = PRIORITY_MAP_I[prio_field*SVS_PRIO_W +: SVS_PRIO_W];
        end else begin
            EFFECTIVE_PRIORITY_O = prio_field;
        end
    end
endmodule

//--- testbench/svs_sysregs_checker.sv
// checker: handshake and access outcome properties of the system registers
module svs_sysregs_checker
    import svs_pkg::*;
(
    // clock and reset
    input wire logic        CORE_CLK_I,
    input wire logic        RST_N_I,
    // move port
    input wire logic        MOVE_VALID_I,
    input wire logic        MOVE_WRITE_I,
    input wire logic [2:0]  MOVE_SEL_I,
    input wire logic        MOVE_READY_O,
    input wire logic        RESP_VALID_O,
    input wire logic [2:0]  RESP_KIND_O,
    input wire logic [1:0]  RESP_TRAP_EL_O,
    input wire logic [5:0]  RESP_TRAP_CLASS_O,
    input wire logic [11:0] RESP_VIRTUALIZATION_MEMORY_PAGE_OFFSET_O,
    // state and controls
    input wire logic [1:0]  CUR_EL_I,
    input wire logic        STREAMING_MODE_I,
    input wire logic        HALTED_I,
    input wire logic [1:0]  LEVEL1_STREAM_ACCESS_ENABLE_I,
    input wire logic        LEVEL3_STREAM_ENABLE_I,
    input wire logic        FULL_SET_LEGAL_O,
    input wire logic [4:0]  STREAMING_VECTOR_LENGTH_O
);
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    sequence s_taken;
        MOVE_VALID_I && MOVE_READY_O;
    endsequence
    sequence s_ctrl_at_el3;
        s_taken ##0 (CUR_EL_I == SVS_EL3 && MOVE_SEL_I <= SVS_SEL_CTRL_TOP);
    endsequence
    a_answer_next: assert property (s_taken |=> RESP_VALID_O && !MOVE_READY_O)
        else $error("no answer in the cycle after a taken request");
    a_resp_single: assert property (RESP_VALID_O |=> !RESP_VALID_O && MOVE_READY_O)
        else $error("answer pulse longer than one cycle");
    a_level3_trap: assert property (s_ctrl_at_el3 ##0 !LEVEL3_STREAM_ENABLE_I |=>
        RESP_KIND_O == SVS_RES_TRAP && RESP_TRAP_EL_O == SVS_EL3
        && RESP_TRAP_CLASS_O == SVS_EC_TRAP_CTRL) else $error("level 3 control trap missing");
    a_level1_trap: assert property (s_taken ##0 (CUR_EL_I == SVS_EL1 && MOVE_WRITE_I
        && MOVE_SEL_I == SVS_SEL_CTRL_LOW && !LEVEL1_STREAM_ACCESS_ENABLE_I[0] && !HALTED_I)
        |=> RESP_KIND_O == SVS_RES_TRAP && RESP_TRAP_EL_O == SVS_EL1)
        else $error("level 1 control trap missing");
    a_top_undef: assert property (s_taken ##0 (MOVE_SEL_I == SVS_SEL_CTRL_TOP
        && CUR_EL_I != SVS_EL3) |=> RESP_KIND_O == SVS_RES_UNDEF)
        else $error("top control reachable below level 3");
    a_virtualization_memory_page_offset: assert property (RESP_VALID_O && RESP_KIND_O == SVS_RES_VIRTUALIZATION_MEMORY_PAGE
        |-> RESP_VIRTUALIZATION_MEMORY_PAGE_OFFSET_O == SVS_VIRTUALIZATION_MEMORY_PAGE_CTRL) else $error("wrong memory page offset");
    a_idle_length: assert property (!STREAMING_MODE_I |->
        STREAMING_VECTOR_LENGTH_O == 5'h00 && !FULL_SET_LEGAL_O)
        else $error("streaming controls active outside streaming mode");
    a_ident_class: assert property (s_taken ##0 (CUR_EL_I == SVS_EL0 && !MOVE_WRITE_I
        && MOVE_SEL_I == SVS_SEL_IDENT) |=> RESP_KIND_O == SVS_RES_TRAP
        && RESP_TRAP_CLASS_O == SVS_EC_TRAP_SYS) else $error("level 0 ident read not trapped");
endmodule

bind svs_sysregs svs_sysregs_checker u_svs_sysregs_checker (.CORE_CLK_I, .RST_N_I,
    .MOVE_VALID_I, .MOVE_WRITE_I, .MOVE_SEL_I, .MOVE_READY_O, .RESP_VALID_O, .RESP_KIND_O,
    .RESP_TRAP_EL_O, .RESP_TRAP_CLASS_O, .RESP_VIRTUALIZATION_MEMORY_PAGE_OFFSET_O, .CUR_EL_I, .STREAMING_MODE_I,
    .HALTED_I, .LEVEL1_STREAM_ACCESS_ENABLE_I, .LEVEL3_STREAM_ENABLE_I, .FULL_SET_LEGAL_O,
    .STREAMING_VECTOR_LENGTH_O);

//--- testbench/streaming_vector_sysregs_test.sv
// testbench: directed scenarios for the streaming vector system registers
module streaming_vector_sysregs_test
    import svs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst_n, valid, wr, str, l2en, hredir, nve, nvl1, nvmr, l3en;
    logic        troute, idtrap, pme, halt, sdbg, l2trap;
    logic        ready, rvalid, fsl;
    logic [1:0]  el, l1en, l2acc, tel;
    logic [2:0]  sel, kind;
    logic [3:0]  eprio;
    logic [4:0]  vlen;
    logic [5:0]  tcls;
    logic [11:0] nvoff;
    logic [63:0] wdata, pmap, rdata, nvdata, lowo, hypo;
    int          n_mismatch, check_count;

    svs_sysregs #(.IMPLEMENTER(8'hA5), .REVISION(8'h3C), .UNIT_AFFINITY(12'h2B7)) u_svs_sysregs (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .MOVE_VALID_I(valid), .MOVE_WRITE_I(wr),
        .MOVE_SEL_I(sel), .MOVE_WDATA_I(wdata), .MOVE_READY_O(ready), .RESP_VALID_O(rvalid),
        .RESP_KIND_O(kind), .RESP_TRAP_EL_O(tel), .RESP_TRAP_CLASS_O(tcls),
        .RESP_RDATA_O(rdata), .RESP_VIRTUALIZATION_MEMORY_PAGE_OFFSET_O(nvoff), .RESP_VIRTUALIZATION_MEMORY_PAGE_DATA_O(nvdata),
        .CUR_EL_I(el), .STREAMING_MODE_I(str), .HALTED_I(halt), .SECURE_DEBUG_DISABLE_I(sdbg),
        .LEVEL2_ENABLED_I(l2en), .HOST_REDIRECT_I(hredir), .NESTED_VIRT_ENABLE_I(nve),
        .NESTED_VIRT_LEVEL1_I(nvl1), .NESTED_VIRT_MEM_REDIRECT_I(nvmr),
        .LEVEL1_STREAM_ACCESS_ENABLE_I(l1en), .LEVEL2_STREAM_TRAP_I(l2trap),
        .LEVEL2_STREAM_ACCESS_ENABLE_I(l2acc), .LEVEL3_STREAM_ENABLE_I(l3en),
        .GENERAL_TRAP_ROUTING_I(troute), .GROUP1_ID_TRAP_I(idtrap),
        .PRIORITY_MAPPING_ENABLE_I(pme), .PRIORITY_MAP_I(pmap), .FULL_SET_LEGAL_O(fsl),
        .STREAMING_VECTOR_LENGTH_O(vlen), .EFFECTIVE_PRIORITY_O(eprio),
        .STREAMING_CONTROL_LOW_O(lowo), .STREAMING_CONTROL_HYP_O(hypo));

    task automatic report_and_stop();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one access: wait for ready, hold the request over the taking edge, answer follows
    task automatic move(input logic w, input logic [2:0] s, input logic [63:0] d);
        int i = 0;
        while (ready !== 1'b1) begin
            @(posedge clk);
            #1;
            i++;
            if (i > 20) begin
                n_mismatch++;
                report_and_stop();
            end
        end
        valid = 1'b1;
        wr = w;
        sel = s;
        wdata = d;
        @(posedge clk);
        #1;
        valid = 1'b0;
        chk(rvalid, 64'h1);
    endtask

    task automatic resp(input logic [2:0] k, input logic [1:0] e, input logic [5:0] c);
        chk(kind, k);
        chk(tel, e);
        if (k == SVS_RES_TRAP) chk(tcls, c);
    endtask

    task automatic t_length();
        el = SVS_EL3;
        for (int k = 0; k < 16; k++) begin
            move(1'b1, SVS_SEL_CTRL_TOP, 64'hFFFF_FFFF_7FFF_FFF0 | (64'(k[0]) << 31) | k);
            chk(vlen, 64'h1 << ($clog2(k + 2) - 1));
            chk(fsl, k[0]);
            move(1'b0, SVS_SEL_CTRL_TOP, 64'h0);
            chk(rdata, (64'(k[0]) << 31) | k);
        end
        str = 1'b0;
        @(posedge clk);
        #1;
        chk({fsl, vlen}, 64'h0);
        str = 1'b1;
    endtask

    task automatic t_low_path();
        l3en = 1'b0;
        move(1'b1, SVS_SEL_CTRL_LOW, 64'h0000_0000_0000_0005);
        resp(SVS_RES_TRAP, SVS_EL3, SVS_EC_TRAP_CTRL);
        chk(lowo, 64'h0);
        l3en = 1'b1;
        el = SVS_EL1;
        l1en = 2'b10;
        move(1'b1, SVS_SEL_CTRL_LOW, 64'h0000_0000_0000_0005);
        resp(SVS_RES_TRAP, SVS_EL1, SVS_EC_TRAP_CTRL);
        move(1'b1, SVS_SEL_CTRL_TOP, 64'h0);
        resp(SVS_RES_UNDEF, SVS_EL0, 6'h00);
        l1en = 2'b11;
        move(1'b1, SVS_SEL_CTRL_LOW, 64'h0000_0000_0000_0003);
        chk(lowo, 64'h3);
        l2en = 1'b1;
        {nve, nvl1, nvmr} = 3'b111;
        move(1'b1, SVS_SEL_CTRL_LOW, 64'h0123_4567_89AB_CDEF);
        resp(SVS_RES_VIRTUALIZATION_MEMORY_PAGE, SVS_EL0, 6'h00);
        chk({nvoff, lowo}, {SVS_VIRTUALIZATION_MEMORY_PAGE_CTRL, 64'h3});
        chk(nvdata, 64'h0123_4567_89AB_CDEF);
        {nve, nvl1, nvmr} = 3'b000;
        el = SVS_EL2;
        hredir = 1'b1;
        move(1'b1, SVS_SEL_CTRL_LOW, 64'h0000_0000_0000_0009);
        resp(SVS_RES_DONE, SVS_EL0, 6'h00);
        chk({hypo, lowo}, {64'h9, 64'h3});
        hredir = 1'b0;
    endtask

    task automatic t_el2_traps();
        el = SVS_EL2;
        l2trap = 1'b1;
        move(1'b1, SVS_SEL_CTRL_LOW, 64'h0000_0000_0000_000C);
        resp(SVS_RES_TRAP, SVS_EL2, SVS_EC_TRAP_CTRL);
        l2trap = 1'b0;
        hredir = 1'b1;
        l2acc = 2'b10;
        move(1'b1, SVS_SEL_CTRL_LOW, 64'h0000_0000_0000_000C);
        resp(SVS_RES_TRAP, SVS_EL2, SVS_EC_TRAP_CTRL);
        l2acc = 2'b01;
        l3en = 1'b0;
        {halt, sdbg} = 2'b11;
        move(1'b1, SVS_SEL_CTRL_LOW, 64'h0000_0000_0000_000C);
        resp(SVS_RES_UNDEF, SVS_EL0, 6'h00);
        {halt, sdbg} = 2'b00;
        move(1'b1, SVS_SEL_CTRL_LOW, 64'h0000_0000_0000_000C);
        resp(SVS_RES_TRAP, SVS_EL3, SVS_EC_TRAP_CTRL);
        chk({hypo, lowo}, {64'h9, 64'h3});
        l3en = 1'b1;
        hredir = 1'b0;
        move(1'b0, SVS_SEL_CTRL_HYP, 64'h0);
        resp(SVS_RES_DONE, SVS_EL0, 6'h00);
        chk(rdata, 64'h9);
        el = SVS_EL1;
        l2trap = 1'b1;
        move(1'b1, SVS_SEL_CTRL_LOW, 64'h0000_0000_0000_000C);
        resp(SVS_RES_TRAP, SVS_EL2, SVS_EC_TRAP_CTRL);
        chk(lowo, 64'h3);
        l2trap = 1'b0;
    endtask

    task automatic t_ident();
        el = SVS_EL3;
        move(1'b0, SVS_SEL_IDENT, 64'h0);
        chk(rdata, 64'h0000_0000_A53C_82B7);
        el = SVS_EL1;
        idtrap = 1'b1;
        move(1'b0, SVS_SEL_IDENT, 64'h0);
        resp(SVS_RES_TRAP, SVS_EL2, SVS_EC_TRAP_SYS);
        idtrap = 1'b0;
        el = SVS_EL0;
        troute = 1'b1;
        move(1'b0, SVS_SEL_IDENT, 64'h0);
        resp(SVS_RES_TRAP, SVS_EL2, SVS_EC_TRAP_SYS);
        troute = 1'b0;
        move(1'b0, SVS_SEL_IDENT, 64'h0);
        resp(SVS_RES_TRAP, SVS_EL1, SVS_EC_TRAP_SYS);
    endtask

    task automatic t_prio();
        el = SVS_EL3;
        move(1'b1, SVS_SEL_PRIO, 64'hFFFF_FFFF_FFFF_FFF9);
        move(1'b0, SVS_SEL_PRIO, 64'h0);
        chk(rdata, 64'h9);
        chk(eprio, 64'h9);
        el = SVS_EL1;
        pme = 1'b1;
        pmap = 64'h0123_4567_89AB_CDEF;
        @(posedge clk);
        #1;
        chk(eprio, 64'h6);
        pme = 1'b0;
        @(posedge clk);
        #1;
        chk(eprio, 64'h9);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        {rst_n, valid, wr, l2en, hredir, nve, nvl1, nvmr, troute, idtrap, pme} = '0;
        {halt, sdbg, l2trap} = 3'b000;
        {str, l3en} = 2'b11;
        {el, l1en, l2acc, sel} = {SVS_EL3, 2'b11, 2'b01, 3'h0};
        {wdata, pmap} = '0;
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_length();
        t_low_path();
        t_el2_traps();
        t_ident();
        t_prio();
        report_and_stop();
    end
endmodule
